// [logic/ftc_cfg_map.vh]
// register offsets, field positions, reset values and timing for ftc config
`ifndef FTC_CFG_MAP_VH
`define FTC_CFG_MAP_VH
// ============================================================
// register offsets
`define FTC_OFS_FAN_POLE_COUNTS      8'h03
`define FTC_OFS_PIN_OVERTEMP_CONFIG  8'h04
`define FTC_OFS_CONV_RATE_SELECT     8'h05
`define FTC_OFS_FAULT_QUEUE_DEPTH    8'h06
`define FTC_OFS_FAN_BEHAVIOUR_CTRL   8'h07
// ============================================================
// reset values
`define FTC_RST_FAN_POLE_COUNTS      8'h44
`define FTC_RST_PIN_OVERTEMP_CONFIG  8'h00
`define FTC_RST_CONV_RATE_SELECT     8'h07
`define FTC_RST_FAULT_QUEUE_DEPTH    8'h01
`define FTC_RST_FAN_BEHAVIOUR_CTRL   8'h09
// ============================================================
// writable bit masks, everything else reserved and read as zero
`define FTC_WMASK_FAN_POLE_COUNTS    8'hFF
`define FTC_WMASK_PIN_OVERTEMP_CFG   8'hFF
`define FTC_WMASK_CONV_RATE_SELECT   8'h0F
`define FTC_WMASK_FAULT_QUEUE_DEPTH  8'h0F
`define FTC_WMASK_FAN_BEHAVIOUR      8'hCF
// ============================================================
// field positions
`define FTC_POLE2_MSB        7
`define FTC_POLE2_LSB        4
`define FTC_POLE1_MSB        3
`define FTC_POLE1_LSB        0
`define FTC_PIN_REF_BIT      7
`define FTC_WIN_MSB          6
`define FTC_WIN_LSB          4
`define FTC_XOR_TEST_BIT     3
`define FTC_REM2_EVT_BIT     2
`define FTC_REM1_EVT_BIT     1
`define FTC_LOCAL_EVT_BIT    0
`define FTC_RATE_MSB         3
`define FTC_RATE_LSB         0
`define FTC_FQ_MSB           3
`define FTC_FQ_LSB           0
`define FTC_FAN2_OFF_BIT     7
`define FTC_FAN1_OFF_BIT     6
`define FTC_SRC2_MSB         3
`define FTC_SRC2_LSB         2
`define FTC_SRC1_MSB         1
`define FTC_SRC1_LSB         0
// ============================================================
// codes
`define FTC_RATE_MAX_CODE    4'hA
`define FTC_SRC_FULL_SPEED   2'h3
// ============================================================
// overtemp duty window, 0.25 s base, clock 125 MHz
`define FTC_WIN_BASE_MS      250
`define FTC_CLK_MHZ          125
`define FTC_WIN_BASE_CYCLES  (`FTC_WIN_BASE_MS * 1000 * `FTC_CLK_MHZ)
`endif

// [logic/ftc_field_decode.v]
// decode of window, fault queue and conversion rate codes
`include "ftc_cfg_map.vh"

module ftc_field_decode (
  input  wire [2:0] window_code,
  input  wire [3:0] queue_code,
  input  wire [3:0] rate_code,
  output reg  [5:0] window_quarters,
  output reg  [2:0] queue_count,
  output reg  [3:0] rate_log2
);

  // ============================================================
  // window in quarter seconds, codes above 100 clamp to 8 s
  always @* begin
    case (window_code)
      3'h0:    window_quarters = 6'h01;
      3'h1:    window_quarters = 6'h02;
      3'h2:    window_quarters = 6'h04;
      3'h3:    window_quarters = 6'h08;
      3'h4:    window_quarters = 6'h10;
      default: window_quarters = 6'h20;
    endcase
  end

  // ============================================================
  // fault queue, highest set bit wins, lsb is a don't care
  always @* begin
    if (queue_code[3]) begin
      queue_count = 3'h4;
    end else if (queue_code[2]) begin
      queue_count = 3'h3;
    end else if (queue_code[1]) begin
      queue_count = 3'h2;
    end else begin
      queue_count = 3'h1;
    end
  end

  // ============================================================
  // rate as power of two of 1/16 conv/s; undefined codes clamp to 64
  always @* begin
    if (rate_code > `FTC_RATE_MAX_CODE) begin
      rate_log2 = `FTC_RATE_MAX_CODE;
    end else begin
      rate_log2 = rate_code;
    end
  end

endmodule

// [logic/ftc_config_regs.v]
// configuration register bank of the thermal monitor and fan controller
`include "ftc_cfg_map.vh"

module ftc_config_regs (
  input  wire       clk,
  input  wire       reset_n,
  // register port from the serial interface engine
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_write,
  input  wire       reg_read,
  output reg  [7:0] reg_rdata,
  output reg        reg_hit,
  // bits held in neighbouring configuration registers
  input  wire       lock_bit,
  input  wire       sw_reset_req,
  input  wire       overtemp_timer_en,
  // monitor status
  input  wire       round_robin_start,
  input  wire       local_over_limit,
  input  wire       remote1_over_limit,
  input  wire       remote2_over_limit,
  input  wire       fault_sample_valid,
  input  wire       fault_sample_bad,
  input  wire       fan_fault_in,
  // control outputs
  output reg  [3:0] fan2_pole_count,
  output reg  [3:0] fan1_pole_count,
  output reg        pin_is_overtemp_ref,
  output reg        fan_fault_out,
  output reg        xor_test_mode,
  output reg        overtemp_signal_out,
  output reg  [5:0] overtemp_duty_window,
  output reg        window_tick,
  output reg  [3:0] active_rate_code,
  output reg  [2:0] fault_queue_count,
  output reg        fault_alert,
  output reg        first_fan_off,
  output reg        second_fan_off,
  output reg  [1:0] first_drive_source_select,
  output reg  [1:0] second_drive_source_select,
  output reg        first_drive_full_speed,
  output reg        second_drive_full_speed,
  output reg        sw_reset_done
);

  // ============================================================
  // storage
  reg  [7:0]  pole_reg;
  reg  [7:0]  pin_cfg_reg;
  reg  [7:0]  rate_reg;
  reg  [7:0]  fq_reg;
  reg  [7:0]  fan_bhv_reg;
  reg  [31:0] win_cnt_reg;
  reg  [5:0]  quarter_cnt_reg;
  reg  [2:0]  fault_run_reg;
  wire [5:0]  window_quarters;
  wire [2:0]  queue_count;
  wire [3:0]  rate_log2;
  wire        wr_ok;

  // merge write data under a mask so reserved bits stay zero
  function [7:0] masked_write;
    input [7:0] wdata;
    input [7:0] wmask;
    begin
      masked_write = wdata & wmask;
    end
  endfunction

  // ============================================================
  // field decoders
  ftc_field_decode u_decode (
    .window_code     (pin_cfg_reg[`FTC_WIN_MSB:`FTC_WIN_LSB]),
    .queue_code      (fq_reg[`FTC_FQ_MSB:`FTC_FQ_LSB]),
    .rate_code       (rate_reg[`FTC_RATE_MSB:`FTC_RATE_LSB]),
    .window_quarters (window_quarters),
    .queue_count     (queue_count),
    .rate_log2       (rate_log2)
  );

  // writes refused while locked or while a software reset is pending
  assign wr_ok = reg_write & ~lock_bit & ~sw_reset_req;

  // ============================================================
  // register writes, software reset restores every default here
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pole_reg    <= `FTC_RST_FAN_POLE_COUNTS;
      pin_cfg_reg <= `FTC_RST_PIN_OVERTEMP_CONFIG;
      rate_reg    <= `FTC_RST_CONV_RATE_SELECT;
      fq_reg      <= `FTC_RST_FAULT_QUEUE_DEPTH;
      fan_bhv_reg <= `FTC_RST_FAN_BEHAVIOUR_CTRL;
    end else if (sw_reset_req) begin
      pole_reg    <= `FTC_RST_FAN_POLE_COUNTS;
      pin_cfg_reg <= `FTC_RST_PIN_OVERTEMP_CONFIG;
      rate_reg    <= `FTC_RST_CONV_RATE_SELECT;
      fq_reg      <= `FTC_RST_FAULT_QUEUE_DEPTH;
      fan_bhv_reg <= `FTC_RST_FAN_BEHAVIOUR_CTRL;
    end else if (wr_ok) begin
      case (reg_addr)
        `FTC_OFS_FAN_POLE_COUNTS: begin
          // odd counts are kept as written; host should use even ones
          pole_reg <= masked_write(reg_wdata,
                                   `FTC_WMASK_FAN_POLE_COUNTS);
        end
        `FTC_OFS_PIN_OVERTEMP_CONFIG: begin
          pin_cfg_reg <= masked_write(reg_wdata,
                                      `FTC_WMASK_PIN_OVERTEMP_CFG);
        end
        `FTC_OFS_CONV_RATE_SELECT: begin
          // bit 7 dropped even if host writes it anyway
          rate_reg <= masked_write(reg_wdata,
                                   `FTC_WMASK_CONV_RATE_SELECT);
        end
        `FTC_OFS_FAULT_QUEUE_DEPTH: begin
          fq_reg <= masked_write(reg_wdata,
                                 `FTC_WMASK_FAULT_QUEUE_DEPTH);
        end
        `FTC_OFS_FAN_BEHAVIOUR_CTRL: begin
          fan_bhv_reg <= masked_write(reg_wdata, `FTC_WMASK_FAN_BEHAVIOUR);
        end
        default: begin
          pole_reg <= pole_reg;
        end
      endcase
    end
  end

  // ============================================================
  // read port, registered; unmapped offsets give zero and no hit
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
      reg_hit   <= 1'b0;
    end else if (reg_read) begin
      reg_hit <= 1'b1;
      case (reg_addr)
        `FTC_OFS_FAN_POLE_COUNTS:     reg_rdata <= pole_reg;
        `FTC_OFS_PIN_OVERTEMP_CONFIG: reg_rdata <= pin_cfg_reg;
        `FTC_OFS_CONV_RATE_SELECT:    reg_rdata <= rate_reg;
        `FTC_OFS_FAULT_QUEUE_DEPTH:   reg_rdata <= fq_reg;
        `FTC_OFS_FAN_BEHAVIOUR_CTRL:  reg_rdata <= fan_bhv_reg;
        default: begin
          reg_rdata <= 8'h00;
          reg_hit   <= 1'b0;
        end
      endcase
    end else begin
      reg_rdata <= 8'h00;
      reg_hit   <= 1'b0;
    end
  end

  // ============================================================
  // static control fields
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fan2_pole_count            <= 4'h4;
      fan1_pole_count            <= 4'h4;
      pin_is_overtemp_ref        <= 1'b0;
      fan_fault_out              <= 1'b0;
      xor_test_mode              <= 1'b0;
      overtemp_duty_window       <= 6'h01;
      first_fan_off              <= 1'b0;
      second_fan_off             <= 1'b0;
      first_drive_source_select  <= 2'h1;
      second_drive_source_select <= 2'h2;
      first_drive_full_speed     <= 1'b0;
      second_drive_full_speed    <= 1'b0;
    end else begin
      fan2_pole_count <= pole_reg[`FTC_POLE2_MSB:`FTC_POLE2_LSB];
      fan1_pole_count <= pole_reg[`FTC_POLE1_MSB:`FTC_POLE1_LSB];
      pin_is_overtemp_ref <= pin_cfg_reg[`FTC_PIN_REF_BIT];
      // fault output only when the pin is not used as reference
      fan_fault_out <= fan_fault_in &
                       ~pin_cfg_reg[`FTC_PIN_REF_BIT];
      xor_test_mode <= pin_cfg_reg[`FTC_XOR_TEST_BIT];
      overtemp_duty_window <= window_quarters;
      second_fan_off <= fan_bhv_reg[`FTC_FAN2_OFF_BIT];
      first_fan_off  <= fan_bhv_reg[`FTC_FAN1_OFF_BIT];
      second_drive_source_select <=
        fan_bhv_reg[`FTC_SRC2_MSB:`FTC_SRC2_LSB];
      first_drive_source_select <=
        fan_bhv_reg[`FTC_SRC1_MSB:`FTC_SRC1_LSB];
      second_drive_full_speed <=
        (fan_bhv_reg[`FTC_SRC2_MSB:`FTC_SRC2_LSB] ==
         `FTC_SRC_FULL_SPEED);
      first_drive_full_speed <=
        (fan_bhv_reg[`FTC_SRC1_MSB:`FTC_SRC1_LSB] ==
         `FTC_SRC_FULL_SPEED);
    end
  end

  // ============================================================
  // overtemp output: an enabled channel over limit with timer running
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      overtemp_signal_out <= 1'b0;
    end else begin
      overtemp_signal_out <= overtemp_timer_en & (
        (pin_cfg_reg[`FTC_REM2_EVT_BIT] & remote2_over_limit) |
        (pin_cfg_reg[`FTC_REM1_EVT_BIT] & remote1_over_limit) |
        (pin_cfg_reg[`FTC_LOCAL_EVT_BIT] & local_over_limit));
    end
  end

  // ============================================================
  // duty window timer: quarter-second ticks counted to the window length
  // a window change takes hold at the next quarter boundary
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      win_cnt_reg     <= 32'h00000000;
      quarter_cnt_reg <= 6'h00;
      window_tick     <= 1'b0;
    end else if (win_cnt_reg == (`FTC_WIN_BASE_CYCLES - 1)) begin
      win_cnt_reg <= 32'h00000000;
      if (quarter_cnt_reg >= window_quarters - 6'h01) begin
        quarter_cnt_reg <= 6'h00;
        window_tick     <= 1'b1;
      end else begin
        quarter_cnt_reg <= quarter_cnt_reg + 6'h01;
        window_tick     <= 1'b0;
      end
    end else begin
      win_cnt_reg <= win_cnt_reg + 32'h00000001;
      window_tick <= 1'b0;
    end
  end

  // ============================================================
  // conversion rate: held until a new round robin starts
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      active_rate_code <= 4'h7;
    end else if (round_robin_start) begin
      active_rate_code <= rate_log2;
    end
  end

  // ============================================================
  // fault queue: alert once the run of bad samples reaches the depth
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fault_run_reg     <= 3'h0;
      fault_alert       <= 1'b0;
      fault_queue_count <= 3'h1;
    end else begin
      fault_queue_count <= queue_count;
      if (fault_sample_valid) begin
        if (!fault_sample_bad) begin
          fault_run_reg <= 3'h0;
          fault_alert   <= 1'b0;
        end else if (fault_run_reg + 3'h1 >= queue_count) begin
          fault_run_reg <= queue_count;       // saturate
          fault_alert   <= 1'b1;
        end else begin
          fault_run_reg <= fault_run_reg + 3'h1;
        end
      end
    end
  end

  // ============================================================
  // software reset acknowledge so the owner can self-clear its bit
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sw_reset_done <= 1'b0;
    end else begin
      sw_reset_done <= sw_reset_req;
    end
  end

endmodule

// [verif/ftc_config_checker.sv]
// concurrent checks on the ports of the ftc configuration register bank
module ftc_config_checker (
  input wire logic       clk, reset_n, reg_write, reg_read, reg_hit,
  input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
  input wire logic       lock_bit, sw_reset_req, overtemp_timer_en,
  input wire logic       round_robin_start, local_over_limit,
  input wire logic       remote1_over_limit, remote2_over_limit,
  input wire logic       fault_sample_valid, fault_sample_bad, fan_fault_in,
  input wire logic [3:0] fan2_pole_count, fan1_pole_count, active_rate_code,
  input wire logic       pin_is_overtemp_ref, fan_fault_out, xor_test_mode,
  input wire logic       overtemp_signal_out, window_tick, fault_alert,
  input wire logic [5:0] overtemp_duty_window,
  input wire logic [2:0] fault_queue_count,
  input wire logic       first_fan_off, second_fan_off, sw_reset_done,
  input wire logic [1:0] first_drive_source_select,
  input wire logic [1:0] second_drive_source_select,
  input wire logic       first_drive_full_speed, second_drive_full_speed
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ============================================================
  // register port: read data stands one cycle only
  AST_RDATA_IDLE: assert property (!reg_read |=>
    reg_rdata == 8'h00)
    else $error("read data not zero when idle");
  AST_UNMAPPED_READ: assert property (reg_read &&
    (reg_addr < 8'h03 || reg_addr > 8'h07) |=>
    reg_rdata == 8'h00 && !reg_hit)
    else $error("unmapped read answered");
  AST_MAPPED_HIT: assert property (reg_read && reg_addr >= 8'h03 &&
    reg_addr <= 8'h07 |=> reg_hit) else $error("mapped read missed");
  // ============================================================
  // decoded fields: a locked bank keeps its outputs unless a software reset is requested
  AST_LOCK_HOLDS: assert property (
    (lock_bit && !sw_reset_req)[*2] |=>
    $stable(fan1_pole_count) && $stable(second_drive_source_select) &&
    $stable(pin_is_overtemp_ref)) else $error("locked field changed");
  AST_SWRST_DEFAULTS: assert property (sw_reset_req[*2] |=>
    fan1_pole_count == 4'h4 && fan2_pole_count == 4'h4 && !xor_test_mode &&
    first_drive_source_select == 2'h1 && second_drive_source_select == 2'h2)
    else $error("software reset left fields");
  // rate moves only at a round robin start, never past 64 conv/s
  AST_RATE_HOLD: assert property (!round_robin_start &&
    !sw_reset_req && !sw_reset_done |=> $stable(active_rate_code))
    else $error("rate moved");
  AST_RATE_MAX: assert property (active_rate_code <= 4'hA)
    else $error("rate above top code");
  AST_WINDOW_POW2: assert property ($onehot(overtemp_duty_window))
    else $error("window not a power of two");
  AST_QUEUE_RANGE: assert property (fault_queue_count >= 3'h1 &&
    fault_queue_count <= 3'h4) else $error("fault queue out of range");
  AST_GOOD_CLEARS: assert property (fault_sample_valid &&
    !fault_sample_bad |=> !fault_alert) else $error("alert kept");
  // overtemp output needs the timer and some channel over its limit
  AST_TIMER_GATES: assert property (!overtemp_timer_en |=>
    !overtemp_signal_out) else $error("overtemp without timer");
  AST_NO_OVER: assert property (!(local_over_limit ||
    remote1_over_limit || remote2_over_limit) |=> !overtemp_signal_out)
    else $error("spurious overtemp");
  AST_REF_BLOCKS_FAULT: assert property (pin_is_overtemp_ref ##1
    pin_is_overtemp_ref |-> !fan_fault_out)
    else $error("fan fail on ref pin");
  // fault output follows its input a cycle late unless the pin is a reference
  AST_FAULT_FOLLOWS: assert property ($past(reset_n) |->
    fan_fault_out == ($past(fan_fault_in) && !pin_is_overtemp_ref))
    else $error("fan fail output wrong");
  cover property (fault_alert);
  cover property (overtemp_signal_out);
  cover property (round_robin_start ##2 active_rate_code == 4'hA);
endmodule

bind ftc_config_regs ftc_config_checker u_ftc_chk (.*);

// [verif/ftc_host_model.sv]
// behavioural host that reaches the configuration registers
module ftc_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_hit,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_write,
  output logic            reg_read
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle bus at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
  end
  // one write, taken at the next edge; stale lines then toggle
  task automatic wr(input [7:0] a, input [7:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_wdata = (a == 8'h05) ? (d & 8'h7F) : d;
    reg_write = 1'b1;
    @(posedge clk);
    #1;
    reg_write = 1'b0;
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask
  // one read; data stands just one cycle after the taking edge
  task automatic rd(input [7:0] a, output [7:0] d, output h);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_read = 1'b1;
    @(posedge clk);
    #1;
    reg_read = 1'b0;
    reg_addr = ~reg_addr;
    d = reg_rdata;
    h = reg_hit;
  endtask
endmodule

// [verif/tb.sv]
// self-checking testbench of the ftc configuration register bank
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk = 1'b0, reset_n = 1'b0, lock_bit = 1'b0;
  logic       sw_reset_req = 1'b0, overtemp_timer_en = 1'b0;
  logic       round_robin_start = 1'b0, fan_fault_in = 1'b0;
  logic       fault_sample_valid = 1'b0, fault_sample_bad = 1'b0;
  logic [2:0] over_lim = 3'h0;
  wire  [7:0] reg_addr, reg_wdata, reg_rdata;
  wire        reg_write, reg_read, reg_hit, pin_is_overtemp_ref, fan_fault_out;
  wire        xor_test_mode, overtemp_signal_out, window_tick, fault_alert;
  wire        first_fan_off, second_fan_off, sw_reset_done;
  wire        first_drive_full_speed, second_drive_full_speed;
  wire  [3:0] fan2_pole_count, fan1_pole_count, active_rate_code;
  wire  [5:0] overtemp_duty_window;
  wire  [2:0] fault_queue_count;
  wire  [1:0] first_drive_source_select, second_drive_source_select;
  int         errors = 0, compares = 0, i, k;
  logic [7:0] a, r, sh [3:7];

  always #4 clk = ~clk;

  ftc_host_model host (.clk, .reg_rdata, .reg_hit, .reg_addr, .reg_wdata,
    .reg_write, .reg_read);
  ftc_config_regs dut (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata, .reg_hit, .lock_bit, .sw_reset_req,
    .overtemp_timer_en, .round_robin_start, .local_over_limit(over_lim[0]),
    .remote1_over_limit(over_lim[1]), .remote2_over_limit(over_lim[2]),
    .fault_sample_valid, .fault_sample_bad, .fan_fault_in, .fan2_pole_count,
    .fan1_pole_count, .pin_is_overtemp_ref, .fan_fault_out, .xor_test_mode,
    .overtemp_signal_out, .overtemp_duty_window, .window_tick,
    .active_rate_code, .fault_queue_count, .fault_alert, .first_fan_off,
    .second_fan_off, .first_drive_source_select, .second_drive_source_select,
    .first_drive_full_speed, .second_drive_full_speed, .sw_reset_done);

  // ============================================================
  // expectations and shared steps
  function automatic [7:0] fq(input [3:0] c);
    fq = c[3] ? 8'h04 : c[2] ? 8'h03 : c[1] ? 8'h02 : 8'h01;
  endfunction
  task automatic chk(input [7:0] got, input [7:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input [7:0] ad, input [7:0] exp);
    logic [7:0] d;
    logic       h;
    host.rd(ad, d, h);
    chk(d, exp);
    chk({7'h00, h}, {7'h00, (ad >= 8'h03 && ad <= 8'h07)});
  endtask
  // shadow follows accepted writes; reserved bits are dropped
  task automatic wr(input [7:0] ad, input [7:0] d);
    host.wr(ad, d);
    if (!lock_bit && !sw_reset_req)
      sh[ad] = d & ((ad == 8'h05 || ad == 8'h06) ? 8'h0F :
                    (ad == 8'h07) ? 8'hCF : 8'hFF);
  endtask
  task automatic defaults;
    sh[3] = 8'h44;
    sh[4] = 8'h00;
    sh[5] = 8'h07;
    sh[6] = 8'h01;
    sh[7] = 8'h09;
  endtask
  // field outputs trail the register by one more cycle
  task automatic fields;
    repeat (2) @(posedge clk);
    #1;
    chk({fan2_pole_count, fan1_pole_count}, sh[3]);
    chk({7'h00, pin_is_overtemp_ref}, {7'h00, sh[4][7]});
    chk({7'h00, xor_test_mode}, {7'h00, sh[4][3]});
    chk({2'h0, overtemp_duty_window},
        8'h01 << ((sh[4][6:4] > 3'h5) ? 3'h5 : sh[4][6:4]));
    chk({5'h00, fault_queue_count}, fq(sh[6][3:0]));
    chk({second_fan_off, first_fan_off, 2'h0,
         second_drive_source_select, first_drive_source_select}, sh[7]);
    chk({6'h00, second_drive_full_speed,
         first_drive_full_speed}, {6'h00, &sh[7][3:2], &sh[7][1:0]});
    chk({7'h00, fan_fault_out}, {7'h00, fan_fault_in & ~sh[4][7]});
    // a quarter second is far longer than the whole run, so no tick yet
    chk({7'h00, window_tick}, 8'h00);
  endtask
  task automatic sample(input logic bad);
    fault_sample_valid = 1'b1;
    fault_sample_bad = bad;
    @(posedge clk);
    #1;
    fault_sample_valid = 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic stop_test;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ============================================================
  // main sequence
  initial begin
    void'($urandom(35));
    defaults();
    repeat (4) @(posedge clk);
    #1 reset_n = 1'b1;
    for (i = 2; i <= 8; i++) begin
      rd_chk(i[7:0], (i >= 3 && i <= 7) ? sh[i] : 8'h00);
    end
    fields();
    $display("test defaults done");
    repeat (40) begin
      a = 8'h03 + 8'($urandom_range(4));
      fan_fault_in = 1'($urandom);
      wr(a, 8'($urandom));
      rd_chk(a, sh[a]);
    end
    fields();
    $display("test random writes done");
    for (i = 0; i < 16; i++) begin
      r = {4'h0, active_rate_code};
      wr(8'h05, 8'($urandom) & 8'hF0 | i[7:0]);
      repeat (2) @(posedge clk);
      #1 chk({4'h0, active_rate_code}, r);
      round_robin_start = 1'b1;
      @(posedge clk);
      #1 round_robin_start = 1'b0;
      @(posedge clk);
      #1 chk({4'h0, active_rate_code}, (i > 10) ? 8'h0A : i[7:0]);
    end
    $display("test rate done");
    lock_bit = 1'b1;
    for (i = 3; i <= 7; i++) wr(i[7:0], ~sh[i]);
    for (i = 3; i <= 7; i++) rd_chk(i[7:0], sh[i]);
    fields();
    lock_bit = 1'b0;
    $display("test lock done");
    wr(8'h04, 8'hFF);
    sw_reset_req = 1'b1;
    wr(8'h03, 8'h22);
    chk({7'h00, sw_reset_done}, 8'h01);
    sw_reset_req = 1'b0;
    defaults();
    for (i = 3; i <= 7; i++) rd_chk(i[7:0], sh[i]);
    chk({7'h00, sw_reset_done}, 8'h00);
    fields();
    $display("test software reset done");
    for (i = 0; i < 3; i++) begin
      wr(8'h04, 8'h01 << i);
      overtemp_timer_en = 1'b1;
      over_lim = 3'h1 << i;
      repeat (3) @(posedge clk);
      #1 chk({7'h00, overtemp_signal_out}, 8'h01);
      over_lim = ~(3'h1 << i);
      repeat (3) @(posedge clk);
      #1 chk({7'h00, overtemp_signal_out}, 8'h00);
      over_lim = 3'h1 << i;
      overtemp_timer_en = 1'b0;
      repeat (3) @(posedge clk);
      #1 chk({7'h00, overtemp_signal_out}, 8'h00);
    end
    $display("test overtemp done");
    for (i = 0; i < 16; i++) begin
      wr(8'h06, i[7:0]);
      sample(1'b0);
      for (k = 1; k <= fq(i[3:0]); k++) begin
        sample(1'b1);
        chk({7'h00, fault_alert}, {7'h00, k == fq(i[3:0])});
      end
      sample(1'b0);
      chk({7'h00, fault_alert}, 8'h00);
    end
    $display("test fault queue done");
    // mid-run reset must undo writes, the live rate and a raised alert
    wr(8'h04, 8'hF8);
    wr(8'h07, 8'hFF);
    wr(8'h06, 8'h00);
    sample(1'b1);
    chk({7'h00, fault_alert}, 8'h01);
    reset_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 reset_n = 1'b1;
    defaults();
    chk({4'h0, active_rate_code}, 8'h07);
    chk({7'h00, fault_alert}, 8'h00);
    for (i = 3; i <= 7; i++) rd_chk(i[7:0], sh[i]);
    fields();
    $display("test mid-run reset done");
    stop_test();
  end

  // watchdog far beyond the several hundred cycles the tests take
  initial begin
    #400000;
    errors++;
    $display("[ERR] t=%0t got %h exp %h", $time, 8'h00, 8'h01);
    stop_test();
  end
endmodule
